// *** core/rtc_pkg.sv ***
// Purpose: shared constants for the transceiver control block and its host
// Assumes: 20 MHz clock, 3-wire serial frame of 16 bits, msb first
// Notes: command 2 bits, address 6 bits, data 8 bits
package rtc_pkg;
    localparam logic [1:0] CMD_NOP = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_RESET = 2'h3;
    localparam logic [5:0] ADDR_CONFIG0 = 6'h02;
    localparam logic [5:0] ADDR_CONTROL = 6'h01;
    localparam logic [5:0] ADDR_TX_LOW_UPPER = 6'h0D;
    localparam logic [5:0] ADDR_TX_LOW_LOWER = 6'h0E;
    localparam logic [5:0] ADDR_TX_HIGH_UPPER = 6'h0F;
    localparam logic [5:0] ADDR_TX_HIGH_LOWER = 6'h10;
    localparam int CFG_TX_SEL_BIT = 6;
    localparam int CFG_FSK_BIT = 2;
    localparam int CTL_TRACK_BIT = 5;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] FREQ_RESET = 8'h00;
    localparam int FRAME_BITS = 16;
    localparam int CLK_HZ = 20000000;
    // short automatic track pulse
    localparam int TRACK_PULSE_NS = 2000;
    localparam int TRACK_CYCLES = (TRACK_PULSE_NS * (CLK_HZ / 1000000) + 999)
        / 1000;
    // serial clock: half period in core cycles
    localparam int SCLK_HALF = 4;
    // host word offset: divide ratio minus 16, times 4096
    localparam int FREQ_OFFSET = 16;
    localparam int FREQ_SCALE = 4096;
endpackage

// *** core/rtc_link_if.sv ***
// Purpose: 3-wire serial link plus tx/rx select pin between host and device
// Assumes: host drives sclk and cs_n; dio is shared, resolved here
// Notes: both enables low leaves dio pulled low
`timescale 1ns/100ps
interface rtc_link_if;
    logic sclk;
    logic cs_n;
    logic dio_host_o;
    logic dio_host_oe;
    logic dio_dev_o;
    logic dio_dev_oe;
    logic tx_sel_pin;
    logic dio;
    assign dio = dio_host_oe ? dio_host_o : (dio_dev_oe ? dio_dev_o : 1'b0);
    modport device (input sclk, cs_n, dio, tx_sel_pin,
        output dio_dev_o, dio_dev_oe);
    modport host (output sclk, cs_n, dio_host_o, dio_host_oe, tx_sel_pin,
        input dio);
endinterface

// *** core/rtc_device.sv ***
// Purpose: transceiver control: frequency words, tx/rx switch, peak track
// Assumes: link pins asynchronous to clk, three-stage synchronised
// Notes: analog blocks see only the control levels driven here
// Operation
// - force bit set makes detectors follow input
// - force bit clear restores fast-attack, slow-decay
// - brief automatic track on four events
// - host writes force bit over serial
// - host computes word as (ratio-16)*4096
// - low word bytes at 0x0D, 0x0E
// - high word bytes at 0x0F, 0x10
// - FSK transmits low and high words
// - ASK uses only the low word
// - receive: switch open, amplifier off
// - transmit: switch closed, tank completed
// - tx/rx by pin or config bit 6
// - host pin high transmit, low receive
// - config register at address 0x02
`timescale 1ns/100ps
module rtc_device
    import rtc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link to host
    rtc_link_if.device link,
    // analog side inputs
    input wire logic tx_data,
    input wire logic agc_gain_switch,
    input wire logic drx_wake,
    // analog side controls
    output logic [15:0] synth_word,
    output logic antenna_switch_closed,
    output logic amp_enable,
    output logic peak_track,
    output logic fsk_mode
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] dio_s;
    logic [2:0] pin_s;
    logic sclk_q;
    logic cs_q;
    logic dio_q;
    logic pin_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            dio_s <= 3'h0;
            pin_s <= 3'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], link.sclk};
            cs_s <= {cs_s[1:0], link.cs_n};
            dio_s <= {dio_s[1:0], link.dio};
            pin_s <= {pin_s[1:0], link.tx_sel_pin};
        end
    end
    // a level counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            dio_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
            if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
            if (dio_s[1] == dio_s[2]) dio_q <= dio_s[2];
            if (pin_s[1] == pin_s[2]) pin_q <= pin_s[2];
        end
    end
    // ------------------------------------------------------------------
    // serial frame receiver
    // ------------------------------------------------------------------
    logic sclk_prev;
    logic sclk_rise;
    logic sclk_fall;
    logic [15:0] shift;
    logic [4:0] bit_cnt;
    logic frame_done;
    logic [7:0] rd_shift;
    always_ff @(posedge clk) begin
        if (!rst_n) sclk_prev <= 1'b0;
        else sclk_prev <= sclk_q;
    end
    assign sclk_rise = sclk_q && !sclk_prev;
    assign sclk_fall = !sclk_q && sclk_prev;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift <= 16'h0000;
            bit_cnt <= 5'h00;
        end else if (cs_q) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise) begin
            shift <= {shift[14:0], dio_q};
            bit_cnt <= bit_cnt + 5'h01;
        end
    end
    assign frame_done = !cs_q && sclk_rise &&
        (bit_cnt == 5'(FRAME_BITS - 1));
    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0] config0;
    logic [7:0] control;
    logic [7:0] tx_low_word_upper;
    logic [7:0] tx_low_word_lower;
    logic [7:0] tx_high_word_upper;
    logic [7:0] tx_high_word_lower;
    logic [1:0] f_cmd;
    logic [5:0] f_addr;
    logic [7:0] f_data;
    assign f_cmd = shift[14:13];
    assign f_addr = shift[12:7];
    assign f_data = {shift[6:0], dio_q};
    always_ff @(posedge clk) begin
        if (!rst_n || (frame_done && f_cmd == CMD_RESET)) begin
            config0 <= CFG_RESET;
            control <= CTL_RESET;
            tx_low_word_upper <= FREQ_RESET;
            tx_low_word_lower <= FREQ_RESET;
            tx_high_word_upper <= FREQ_RESET;
            tx_high_word_lower <= FREQ_RESET;
        end else if (frame_done && f_cmd == CMD_WRITE) begin
            if (f_addr == ADDR_CONFIG0) config0 <= f_data;
            else if (f_addr == ADDR_CONTROL) control <= f_data;
            else if (f_addr == ADDR_TX_LOW_UPPER) tx_low_word_upper <= f_data;
            else if (f_addr == ADDR_TX_LOW_LOWER) tx_low_word_lower <= f_data;
            else if (f_addr == ADDR_TX_HIGH_UPPER) tx_high_word_upper <= f_data;
            else if (f_addr == ADDR_TX_HIGH_LOWER) tx_high_word_lower <= f_data;
        end
    end
    function automatic logic [7:0] read_mux(input logic [5:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == ADDR_CONFIG0) r = config0;
        else if (a == ADDR_CONTROL) r = control;
        else if (a == ADDR_TX_LOW_UPPER) r = tx_low_word_upper;
        else if (a == ADDR_TX_LOW_LOWER) r = tx_low_word_lower;
        else if (a == ADDR_TX_HIGH_UPPER) r = tx_high_word_upper;
        else if (a == ADDR_TX_HIGH_LOWER) r = tx_high_word_lower;
        return r;
    endfunction
    // read: after the address byte the device drives data on falling edges
    logic rd_active;
    always_ff @(posedge clk) begin
        if (!rst_n || cs_q) begin
            rd_active <= 1'b0;
            rd_shift <= 8'h00;
        end else if (sclk_rise && bit_cnt == 5'h07 &&
            shift[6:5] == CMD_READ) begin
            rd_active <= 1'b1;
            rd_shift <= read_mux({shift[4:0], dio_q});
        end else if (rd_active && sclk_fall && bit_cnt != 5'h08) begin
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.dio_dev_o <= 1'b0;
            link.dio_dev_oe <= 1'b0;
        end else begin
            link.dio_dev_oe <= rd_active && !cs_q;
            link.dio_dev_o <= rd_shift[7];
        end
    end
    // ------------------------------------------------------------------
    // tx/rx selection and synthesizer word
    // ------------------------------------------------------------------
    logic tx_mode;
    logic tx_mode_prev;
    assign tx_mode = pin_q || config0[CFG_TX_SEL_BIT];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            antenna_switch_closed <= 1'b0;
            amp_enable <= 1'b0;
            fsk_mode <= 1'b0;
            synth_word <= 16'h0000;
        end else begin
            antenna_switch_closed <= tx_mode;
            amp_enable <= tx_mode;
            fsk_mode <= config0[CFG_FSK_BIT];
            if (config0[CFG_FSK_BIT] && tx_data)
                synth_word <= {tx_high_word_upper, tx_high_word_lower};
            else
                synth_word <= {tx_low_word_upper, tx_low_word_lower};
        end
    end
    // ------------------------------------------------------------------
    // peak detector tracking
    // ------------------------------------------------------------------
    logic [7:0] trk_cnt;
    logic power_up;
    logic auto_evt;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_mode_prev <= 1'b0;
            power_up <= 1'b1;
        end else begin
            tx_mode_prev <= tx_mode;
            power_up <= 1'b0;
        end
    end
    assign auto_evt = power_up || (tx_mode_prev && !tx_mode) ||
        drx_wake || agc_gain_switch;
    always_ff @(posedge clk) begin
        if (!rst_n) trk_cnt <= 8'h00;
        else if (auto_evt) trk_cnt <= 8'(TRACK_CYCLES);
        else if (trk_cnt != 8'h00) trk_cnt <= trk_cnt - 8'h01;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) peak_track <= 1'b0;
        else peak_track <= control[CTL_TRACK_BIT] || auto_evt ||
            (trk_cnt != 8'h00);
    end
endmodule // rtc_device

// *** core/rtc_host.sv ***
// Purpose: host end: turns register port orders into serial frames
// Assumes: one frame at a time; orders while busy are dropped
// Notes: read data land in the read byte register (2) of this host
`timescale 1ns/100ps
module rtc_host
    import rtc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // link to device
    rtc_link_if.host link
);
    // ------------------------------------------------------------------
    // host registers: 0 frame order, 1 status, 2 read byte, 3 tx pin
    // ------------------------------------------------------------------
    localparam logic [3:0] H_FRAME = 4'h0;
    localparam logic [3:0] H_STATUS = 4'h1;
    localparam logic [3:0] H_RDATA = 4'h2;
    localparam logic [3:0] H_TXPIN = 4'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b100
    } rtc_hst_t;
    rtc_hst_t state;
    logic [15:0] frame;
    logic [4:0] bit_cnt;
    logic [3:0] div;
    logic [7:0] rd_byte;
    logic tx_pin;
    // command kept aside: the frame register moves one bit every period
    logic [1:0] cmd_q;
    logic start;
    assign start = wr && addr == H_FRAME && state == ST_IDLE;
    always_ff @(posedge clk) begin
        if (!rst_n) tx_pin <= 1'b0;
        else if (wr && addr == H_TXPIN) tx_pin <= wdata[0];
    end
    always_ff @(posedge clk) begin
        if (!rst_n) rdata <= 16'h0000;
        else if (rd) begin
            if (addr == H_STATUS) rdata <= {15'h0000, state != ST_IDLE};
            else if (addr == H_RDATA) rdata <= {8'h00, rd_byte};
            else if (addr == H_TXPIN) rdata <= {15'h0000, tx_pin};
            else rdata <= 16'h0000;
        end
    end
    // ------------------------------------------------------------------
    // frame engine: sclk low half then high half per bit
    // ------------------------------------------------------------------
    // frame words come from software already rounded
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            frame <= 16'h0000;
            bit_cnt <= 5'h00;
            div <= 4'h0;
            rd_byte <= 8'h00;
            cmd_q <= CMD_NOP;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.dio_host_o <= 1'b0;
            link.dio_host_oe <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    link.sclk <= 1'b0;
                    link.cs_n <= 1'b1;
                    link.dio_host_o <= 1'b0;
                    link.dio_host_oe <= 1'b1;
                    if (start) begin
                        frame <= wdata;
                        cmd_q <= wdata[15:14];
                        bit_cnt <= 5'h00;
                        div <= 4'h0;
                        link.cs_n <= 1'b0;
                        link.dio_host_o <= wdata[15];
                        state <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (div == 4'(SCLK_HALF - 1)) begin
                        div <= 4'h0;
                        link.sclk <= 1'b1;
                        state <= ST_HIGH;
                    end else div <= div + 4'h1;
                end
                ST_HIGH: begin
                    if (div == 4'(SCLK_HALF - 1)) begin
                        div <= 4'h0;
                        link.sclk <= 1'b0;
                        if (bit_cnt >= 5'h08 && cmd_q == CMD_READ)
                            rd_byte <= {rd_byte[6:0], link.dio};
                        frame <= {frame[14:0], 1'b0};
                        if (bit_cnt == 5'(FRAME_BITS - 1)) begin
                            state <= ST_IDLE;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                            link.dio_host_o <= frame[14];
                            link.dio_host_oe <= !(bit_cnt >= 5'h07 &&
                                cmd_q == CMD_READ);
                            state <= ST_LOW;
                        end
                    end else div <= div + 4'h1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    assign link.tx_sel_pin = tx_pin;
endmodule // rtc_host

// *** bench/rtc_properties.sv ***
// Purpose: concurrent checks on the link and device control outputs
// Assumes: one clock domain, synchronous active-low reset
// Notes: idle_cnt masks the settling time after serial frames
`timescale 1ns/100ps
module rtc_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link wires
    input wire logic cs_n,
    input wire logic tx_sel_pin,
    // device side
    input wire logic agc_gain_switch,
    input wire logic drx_wake,
    input wire logic [15:0] synth_word,
    input wire logic antenna_switch_closed,
    input wire logic amp_enable,
    input wire logic peak_track,
    input wire logic fsk_mode
);
    logic [3:0] idle_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // --------------------------------------------------
    // link idle counter
    // --------------------------------------------------
    // a write lands a few cycles after the frame, so wait well past it
    always_ff @(posedge clk) begin
        if (!rst_n || !cs_n) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end
    // --------------------------------------------------
    // properties
    // --------------------------------------------------
    a_switch_amp_pair: assert property (
        antenna_switch_closed == amp_enable)
        else $error("switch and amplifier disagree");
    a_ask_data_ignored: assert property (
        !fsk_mode && !$past(fsk_mode) && idle_cnt > 4'h9
        |-> $stable(synth_word))
        else $error("ask word moved with data");
    a_track_powerup: assert property (
        $rose(rst_n) |-> ##[0:3] peak_track)
        else $error("no track pulse after reset");
    a_track_agc: assert property (
        agc_gain_switch |=> ##[0:2] peak_track)
        else $error("no track pulse on gain switch");
    a_track_wake: assert property (
        drx_wake |-> ##[1:3] peak_track)
        else $error("no track pulse on wake");
    a_track_tx_rx: assert property (
        $fell(antenna_switch_closed) |-> ##[0:3] peak_track)
        else $error("no track pulse on tx to rx");
    a_track_hold: assert property (
        $rose(peak_track) |-> peak_track[*8])
        else $error("track pulse too short");
    a_pin_tx: assert property (
        tx_sel_pin[*6] |=> antenna_switch_closed)
        else $error("pin high but switch open");
endmodule // rtc_properties

// *** bench/tb_rf_transceiver_tx_rx_control.sv ***
// Purpose: host and device joined over the link, checked against a model
// Assumes: host register map 0 frame, 1 status, 2 read byte, 3 tx pin
// Notes: track pulses are left to expire before steady checks
`timescale 1ns/100ps
module tb_rf_transceiver_tx_rx_control;
    import rtc_pkg::*;
    logic clk;
    logic rst_n;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic tx_data;
    logic agc_gain_switch;
    logic drx_wake;
    logic [15:0] synth_word;
    logic antenna_switch_closed;
    logic amp_enable;
    logic peak_track;
    logic fsk_mode;
    logic [15:0] m_lo;
    logic [15:0] m_hi;
    logic [7:0] m_cfg;
    logic [7:0] m_ctl;
    logic m_pin;
    logic [15:0] rv;
    integer failures = 0;
    integer check_count = 0;
    integer seed = 20;
    // divide ratios are held in units of 1/10000
    localparam int RATIO_UNIT = 10000;
    localparam int RATIO_HALF = RATIO_UNIT / 2;
    rtc_link_if link_i ();
    rtc_device rtc_device_i (.clk(clk), .rst_n(rst_n), .link(link_i),
        .tx_data(tx_data), .agc_gain_switch(agc_gain_switch),
        .drx_wake(drx_wake), .synth_word(synth_word),
        .antenna_switch_closed(antenna_switch_closed),
        .amp_enable(amp_enable), .peak_track(peak_track),
        .fsk_mode(fsk_mode));
    rtc_host rtc_host_i (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link_i));
    rtc_properties rtc_properties_i (.clk(clk), .rst_n(rst_n),
        .cs_n(link_i.cs_n), .tx_sel_pin(link_i.tx_sel_pin),
        .agc_gain_switch(agc_gain_switch), .drx_wake(drx_wake),
        .synth_word(synth_word),
        .antenna_switch_closed(antenna_switch_closed),
        .amp_enable(amp_enable), .peak_track(peak_track),
        .fsk_mode(fsk_mode));
    // --------------------------------------------------
    // tasks
    // --------------------------------------------------
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask
    // orders sent while busy are dropped, so poll status after each order until idle
    task automatic frame(input logic [1:0] c, input logic [5:0] a,
        input logic [7:0] d);
        logic [15:0] st;
        int n;
        bus_wr(4'h0, {c, a, d});
        st = 16'h0001;
        n = 0;
        while (st[0] !== 1'b0 && n < 200) begin
            bus_rd(4'h1, st);
            n++;
        end
        if (n >= 200) chk("frame_done", st, 16'h0000);
        repeat (12) @(posedge clk);
    endtask
    task automatic wreg(input logic [5:0] a, input logic [7:0] d);
        frame(CMD_WRITE, a, d);
        case (a)
            ADDR_TX_LOW_UPPER: m_lo[15:8] = d;
            ADDR_TX_LOW_LOWER: m_lo[7:0] = d;
            ADDR_TX_HIGH_UPPER: m_hi[15:8] = d;
            ADDR_TX_HIGH_LOWER: m_hi[7:0] = d;
            ADDR_CONFIG0: m_cfg = d;
            ADDR_CONTROL: m_ctl = d;
            default: ;
        endcase
    endtask
    // host word: (ratio - offset) * scale, rounded to nearest
    function automatic logic [15:0] freq_word(input int r);
        return 16'(((r - FREQ_OFFSET * RATIO_UNIT) * FREQ_SCALE +
            RATIO_HALF) / RATIO_UNIT);
    endfunction
    function automatic logic [7:0] mreg(input int k);
        logic [31:0] w;
        w = {m_lo, m_hi};
        return w[31 - 8 * k -: 8];
    endfunction
    task automatic check_out();
        logic tx;
        logic [15:0] exp;
        tx = m_pin | m_cfg[CFG_TX_SEL_BIT];
        exp = (m_cfg[CFG_FSK_BIT] && tx_data) ? m_hi : m_lo;
        chk("synth_word", synth_word, exp);
        chk("fsk", 16'(fsk_mode), 16'(m_cfg[CFG_FSK_BIT]));
        chk("switch", 16'(antenna_switch_closed), 16'(tx));
        chk("amp", 16'(amp_enable), 16'(tx));
    endtask
    // --------------------------------------------------
    // clock, watchdog, sequence
    // --------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #3000000;
        failures++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        {addr, wdata, wr, rd} = '0;
        {tx_data, agc_gain_switch, drx_wake, m_pin} = '0;
        {m_lo, m_hi, m_cfg, m_ctl} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("track_up", 16'(peak_track), 16'h0001);
        repeat (60) @(posedge clk);
        chk("track_idle", 16'(peak_track), 16'h0000);
        frame(CMD_NOP, ADDR_CONFIG0, 8'hFF);
        check_out();
        // random words, both modulations, random data levels
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 4; k++) begin
                wreg(ADDR_TX_LOW_UPPER + 6'(k), 8'($random(seed)));
            end
            wreg(ADDR_CONFIG0, 8'(i[0]) << CFG_FSK_BIT);
            for (int j = 0; j < 4; j++) begin
                tx_data <= 1'($random(seed));
                repeat (3) @(posedge clk);
                check_out();
            end
        end
        for (int k = 0; k < 4; k++) begin
            frame(CMD_READ, ADDR_TX_LOW_UPPER + 6'(k), 8'h00);
            bus_rd(4'h2, rv);
            chk("readback", {8'h00, rv[7:0]}, {8'h00, mreg(k)});
        end
        // every pin and select bit combination
        for (int k = 0; k < 4; k++) begin
            bus_wr(4'h3, 16'(k[0]));
            m_pin = k[0];
            wreg(ADDR_CONFIG0, 8'(k[1]) << CFG_TX_SEL_BIT);
            check_out();
        end
        // ratio between 16 and about 29, ask transmit uses the low word
        rv = freq_word(FREQ_OFFSET * RATIO_UNIT +
            ($random(seed) & 32'h0001FFFF));
        wreg(ADDR_TX_LOW_UPPER, rv[15:8]);
        wreg(ADDR_TX_LOW_LOWER, rv[7:0]);
        chk("ratio_word", synth_word, rv);
        wreg(ADDR_CONFIG0, 8'h00);
        bus_wr(4'h3, 16'h0000);
        m_pin = 1'b0;
        repeat (8) @(posedge clk);
        chk("track_rx", 16'(peak_track), 16'h0001);
        check_out();
        repeat (60) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            agc_gain_switch <= (k == 0);
            drx_wake <= (k == 1);
            @(posedge clk);
            agc_gain_switch <= 1'b0;
            drx_wake <= 1'b0;
            repeat (4) @(posedge clk);
            chk("track_evt", 16'(peak_track), 16'h0001);
            repeat (60) @(posedge clk);
            chk("track_end", 16'(peak_track), 16'h0000);
        end
        wreg(ADDR_CONTROL, 8'h01 << CTL_TRACK_BIT);
        repeat (60) @(posedge clk);
        chk("track_force", 16'(peak_track), 16'h0001);
        wreg(ADDR_CONTROL, 8'h00);
        repeat (60) @(posedge clk);
        chk("track_free", 16'(peak_track), 16'h0000);
        frame(CMD_RESET, 6'h00, 8'h00);
        {m_lo, m_hi} = {4{FREQ_RESET}};
        m_cfg = CFG_RESET;
        check_out();
        stop_test();
    end
endmodule // tb_rf_transceiver_tx_rx_control
